//--- hw/awp_pkg.sv
// Shared constants, types and tables for the nonvolatile memory host controller
package awp_pkg;
    // ****************************************************************
    // Timing, all least times rounded up to whole 25 ns clock cycles
    // ****************************************************************
    localparam int CLK_MHZ = 40;
    localparam int ADDR_SETUP_NS = 10;
    localparam int ACCESS_NS = 100;
    localparam int PRECHARGE_NS = 100;
    localparam int SLEEP_EXIT_NS = 1000;
    localparam logic [7:0] SETUP_CYC = 8'((ADDR_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] ACCESS_CYC = 8'((ACCESS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] PRECH_CYC = 8'((PRECHARGE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] WAKE_CYC = 8'((SLEEP_EXIT_NS * CLK_MHZ + 999) / 1000);

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_SLEEP = 8'h14;
    localparam int CMD_UPPER_OFF = 2;
    localparam int CMD_LOWER_OFF = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ASLEEP = 2;
    localparam int ST_ERR = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_PROTECT = 2'h2} awp_op_t;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_SETUP = 6'h02, S_ACCESS = 6'h04,
        S_PRECH = 6'h08, S_SLEEP = 6'h10, S_WAKE = 6'h20
    } awp_state_t;

    // Memory pin bundle
    typedef struct packed {
        logic chip_sel_n;
        logic write_n;
        logic out_en_n;
        logic upper_byte_n;
        logic lower_byte_n;
        logic sleep_n;
        logic dq_oe_n;
        logic [16:0] addr;
        logic [15:0] dq;
    } awp_pins_t;
    localparam awp_pins_t PINS_RST = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
                                       17'h0_0000, 16'h0000};

    // ****************************************************************
    // Protection change sequence: six reads, three writes, one read
    // ****************************************************************
    localparam logic [3:0] SEQ_LAST = 4'h9;
    localparam logic [3:0] SEQ_BYTE = 4'h6;
    localparam logic [3:0] SEQ_COMPL = 4'h7;
    localparam logic [9:0] SEQ_WRITE = 10'h1C0;
    localparam logic [16:0] SEQ_ADDR [10] = '{
        17'h1_2555, 17'h1_DAAA, 17'h0_1333, 17'h0_ECCC, 17'h0_00FF,
        17'h1_FF00, 17'h1_DAAA, 17'h0_ECCC, 17'h0_FF00, 17'h0_0000
    };
endpackage

//--- hw/awp_host.sv
// Host controller driving the asynchronous nonvolatile memory, AXI4-Lite programmed
//
// Contract
// - Host reaches a new row by dropping chip select anew or changing row bits.
// - Chip select high starts precharge; host holds it high the minimum time.
// - Write strobe low at select fall gives a write; host holds data at select rise.
// - Write runs from strobe fall to first strobe or select rise; one strobe per word.
// - Page writes keep select low, one strobe pulse and column per extra word.
// - Sleep low ignores other pins; finish accesses first, wait exit delay after.
// - Protection byte on the low data lanes; a one protects that sector.
// - Protection change starts with six reads at fixed addresses in order.
// - Then write byte, its complement, any data, and a final read of zero.
// - During the sequence, address stable while selected, with setup before select.
`timescale 1ns/1ps
module awp_host
    import awp_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // AXI4-Lite write channels
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read channels
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Memory pins
    output logic [16:0] MEM_ADDR,
    output logic [15:0] MEM_DQ_O,
    input wire logic [15:0] MEM_DQ_I,
    output logic MEM_DQ_OE_N,
    output logic MEM_CHIP_SEL_N,
    output logic MEM_WRITE_N,
    output logic MEM_OUT_EN_N,
    output logic MEM_UPPER_BYTE_N,
    output logic MEM_LOWER_BYTE_N,
    output logic MEM_SLEEP_N
);
    // ****************************************************************
    // Register file and bus slave
    // ****************************************************************
    awp_state_t st;
    awp_pins_t pins;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [5:0] cmd;
    logic [16:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic done;
    logic err;
    logic sleep_req;
    logic [7:0] cnt;
    logic [3:0] step;
    logic seq;

    // Byte-enable merge so partial-word writes only touch strobed lanes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (nw & m);
    endfunction

    // Write decode; both address and data must have been taken
    wire wr_fire = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
    wire wr_hit = aw_addr == REG_CMD || aw_addr == REG_ADDR || aw_addr == REG_WDATA
                  || aw_addr == REG_STATUS || aw_addr == REG_SLEEP;
    wire wr_cmd = wr_fire && aw_addr == REG_CMD;
    wire launch = wr_cmd && st == S_IDLE && !sleep_req;
    wire [31:0] cmd_new = merge({26'h000_0000, cmd}, w_data, w_strb);
    wire [31:0] stat_clr = wr_fire && aw_addr == REG_STATUS ? (w_data & {{8{w_strb[3]}},
                           {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}}) : 32'h0000_0000;

    // Read decode; status shows live controller state
    wire [31:0] status_word = {28'h000_0000, err, st == S_SLEEP || st == S_WAKE, done,
                               st != S_IDLE};
    wire rd_hit = S_AXI_ARADDR <= REG_SLEEP && S_AXI_ARADDR[1:0] == 2'h0;
    wire [31:0] rd_mux = S_AXI_ARADDR == REG_CMD ? {26'h000_0000, cmd} :
                         S_AXI_ARADDR == REG_ADDR ? {15'h0000, addr_reg} :
                         S_AXI_ARADDR == REG_WDATA ? {16'h0000, wdata_reg} :
                         S_AXI_ARADDR == REG_RDATA ? {16'h0000, rdata_reg} :
                         S_AXI_ARADDR == REG_STATUS ? status_word :
                         S_AXI_ARADDR == REG_SLEEP ? {31'h0000_0000, sleep_req} :
                         32'h0000_0000;

    // Write channel handshakes: address and data accepted in either order
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_addr <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // Read channel: one read outstanding, answer one cycle after address
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= RESP_OKAY;
        end
        else if (S_AXI_ARVALID && S_AXI_ARREADY)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_mux;
            S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // Software registers; a command is only stored when it can start
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cmd <= 6'h00;
            addr_reg <= 17'h0_0000;
            wdata_reg <= 16'h0000;
            sleep_req <= 1'b0;
        end
        else if (wr_fire)
        begin
            if (launch)
                cmd <= cmd_new[5:0];
            if (aw_addr == REG_ADDR)
                addr_reg <= 17'(merge({15'h0000, addr_reg}, w_data, w_strb));
            if (aw_addr == REG_WDATA)
                wdata_reg <= 16'(merge({16'h0000, wdata_reg}, w_data, w_strb));
            if (aw_addr == REG_SLEEP && w_strb[0])
                sleep_req <= w_data[0];
        end
    end

    // ****************************************************************
    // Memory cycle sequencer
    // ****************************************************************
    // Current step's address, direction and data; protection byte on low lanes
    wire [16:0] cur_addr = seq ? SEQ_ADDR[step] : addr_reg;
    wire cur_wr = seq ? SEQ_WRITE[step] : cmd[1:0] == OP_WRITE;
    wire [15:0] cur_data = !seq ? wdata_reg :
                           step == SEQ_BYTE ? {8'h00, wdata_reg[7:0]} :
                           step == SEQ_COMPL ? {8'h00, ~wdata_reg[7:0]} :
                           16'h0000;
    wire seq_more = seq && step != SEQ_LAST;
    wire done_evt = st == S_PRECH && cnt == PRECH_CYC - 8'h01 && !seq_more;
    wire err_evt = wr_cmd && !launch;

    // Sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            done <= 1'b0;
            err <= 1'b0;
        end
        else
        begin
            done <= done_evt || (done && !stat_clr[ST_DONE]);
            err <= err_evt || (err && !stat_clr[ST_ERR]);
        end
    end

    // Every access: address settles with select high, select low, select high again
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            st <= S_IDLE;
            pins <= PINS_RST;
            cnt <= 8'h00;
            step <= 4'h0;
            seq <= 1'b0;
            rdata_reg <= 16'h0000;
        end
        else
        begin
            unique case (st)
                S_IDLE:
                begin
                    cnt <= 8'h00;
                    step <= 4'h0;
                    if (launch)
                    begin
                        seq <= cmd_new[1:0] == OP_PROTECT;
                        st <= S_SETUP;
                    end
                    else if (sleep_req)
                    begin
                        pins.sleep_n <= 1'b0;
                        st <= S_SLEEP;
                    end
                end
                S_SETUP:
                begin
                    // Strobe goes low before select for a select-controlled write
                    pins.addr <= cur_addr;
                    pins.write_n <= !cur_wr;
                    pins.dq <= cur_data;
                    pins.dq_oe_n <= !cur_wr;
                    pins.upper_byte_n <= seq ? 1'b0 : cmd[CMD_UPPER_OFF];
                    pins.lower_byte_n <= seq ? 1'b0 : cmd[CMD_LOWER_OFF];
                    cnt <= cnt + 8'h01;
                    if (cnt == SETUP_CYC)
                    begin
                        pins.chip_sel_n <= 1'b0;
                        pins.out_en_n <= cur_wr;
                        cnt <= 8'h00;
                        st <= S_ACCESS;
                    end
                end
                S_ACCESS:
                begin
                    cnt <= cnt + 8'h01;
                    if (cnt == ACCESS_CYC - 8'h01)
                    begin
                        // Strobe and select rise together: one strobe per word, so no
                        // page write ever starts
                        pins.chip_sel_n <= 1'b1;
                        pins.write_n <= 1'b1;
                        pins.out_en_n <= 1'b1;
                        if (pins.write_n)
                            rdata_reg <= MEM_DQ_I;
                        cnt <= 8'h00;
                        st <= S_PRECH;
                    end
                end
                S_PRECH:
                begin
                    // Data still driven here, so it is valid as select rises
                    cnt <= cnt + 8'h01;
                    if (cnt == PRECH_CYC - 8'h01)
                    begin
                        pins.dq_oe_n <= 1'b1;
                        cnt <= 8'h00;
                        step <= step + 4'h1;
                        st <= seq_more ? S_SETUP : S_IDLE;
                    end
                end
                S_SLEEP:
                    if (!sleep_req)
                    begin
                        pins.sleep_n <= 1'b1;
                        st <= S_WAKE;
                    end
                S_WAKE:
                begin
                    cnt <= cnt + 8'h01;
                    if (cnt == WAKE_CYC - 8'h01)
                        st <= S_IDLE;
                end
            endcase
        end
    end

    // Pins straight from the bundle flip-flops
    assign MEM_ADDR = pins.addr;
    assign MEM_DQ_O = pins.dq;
    assign MEM_DQ_OE_N = pins.dq_oe_n;
    assign MEM_CHIP_SEL_N = pins.chip_sel_n;
    assign MEM_WRITE_N = pins.write_n;
    assign MEM_OUT_EN_N = pins.out_en_n;
    assign MEM_UPPER_BYTE_N = pins.upper_byte_n;
    assign MEM_LOWER_BYTE_N = pins.lower_byte_n;
    assign MEM_SLEEP_N = pins.sleep_n;

    // ****************************************************************
    // Assertions and covers
    // ****************************************************************
    logic [7:0] hi_len;
    logic [7:0] awake_len;

    // Cycles select has been high, and since sleep last ended, saturating
    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            hi_len <= 8'hFF;
            awake_len <= 8'hFF;
        end
        else
        begin
            hi_len <= !pins.chip_sel_n ? 8'h00 : hi_len == 8'hFF ? hi_len : hi_len + 8'h01;
            awake_len <= !pins.sleep_n ? 8'h00 :
                         awake_len == 8'hFF ? awake_len : awake_len + 8'h01;
        end
    end

    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    a_precharge_hold: assert property ($fell(MEM_CHIP_SEL_N) |-> hi_len >= PRECH_CYC)
        else $error("select reasserted before precharge time");
    a_addr_stable: assert property (!MEM_CHIP_SEL_N && $past(!MEM_CHIP_SEL_N)
        |-> $stable(MEM_ADDR))
        else $error("address moved while selected");
    a_addr_setup: assert property ($fell(MEM_CHIP_SEL_N) |-> MEM_ADDR == $past(MEM_ADDR))
        else $error("address not set up before select");
    a_strobe_before_sel: assert property ($fell(MEM_CHIP_SEL_N)
        |-> $stable(MEM_WRITE_N))
        else $error("strobe changed with select fall");
    a_data_held_rise: assert property ($rose(MEM_CHIP_SEL_N) && $past(!MEM_WRITE_N)
        |-> !MEM_DQ_OE_N && $stable(MEM_DQ_O))
        else $error("write data not held at select rise");
    // Strobe low through the four selected cycles, then both rise together
    a_one_strobe_word: assert property ($fell(MEM_WRITE_N) |-> MEM_CHIP_SEL_N ##1
        (!MEM_CHIP_SEL_N && !MEM_WRITE_N)[*4] ##1 (MEM_CHIP_SEL_N && MEM_WRITE_N))
        else $error("strobe pulsed more than once per word");
    a_write_no_oe: assert property (!MEM_WRITE_N |-> MEM_OUT_EN_N)
        else $error("output enable low during write");
    a_sleep_quiet: assert property (!MEM_SLEEP_N |-> MEM_CHIP_SEL_N && MEM_WRITE_N
        && MEM_DQ_OE_N)
        else $error("pins active during sleep");
    a_wake_delay: assert property ($fell(MEM_CHIP_SEL_N) |-> awake_len >= WAKE_CYC)
        else $error("access before sleep exit delay");
    a_seq_address: assert property ($fell(MEM_CHIP_SEL_N) && seq
        |-> MEM_ADDR == SEQ_ADDR[step] && MEM_WRITE_N == !SEQ_WRITE[step])
        else $error("protection sequence step out of order");
    a_seq_complement: assert property ($fell(MEM_CHIP_SEL_N) && seq
        && step == SEQ_COMPL
        |-> MEM_DQ_O[7:0] == ~$past(wdata_reg[7:0]) && !MEM_LOWER_BYTE_N)
        else $error("complement byte wrong");

    c_read_done: cover property (done_evt && !seq && cmd[1:0] == OP_READ);
    c_write_done: cover property (done_evt && !seq && cmd[1:0] == OP_WRITE);
    c_seq_done: cover property (done_evt && seq);
    c_sleep_wake: cover property ($rose(MEM_SLEEP_N));
endmodule

//--- sim/awp_mem_model.sv
// Behavioural model of the nonvolatile memory behind the host controller
`timescale 1ns/1ps
module awp_mem_model
    import awp_pkg::*;
#(
    parameter int ACC_NS = 60
)
(
    // Strobes, all active low
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic upper_byte_n,
    input wire logic lower_byte_n,
    input wire logic slp_n,
    // Address and data
    input wire logic [16:0] addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out
);
    // ************************************************************
    // Array and protection state
    // ************************************************************
    logic [15:0] mem [131072];
    logic [7:0] prot = 8'h00;
    logic [7:0] pend = 8'h00;
    logic [3:0] step = 4'h0;
    logic [16:0] lat = 17'h0_0000;
    logic rd_cyc = 1'b0;
    logic rdy = 1'b0;
    logic wr_open = 1'b0;
    logic [15:0] last = 16'h0000;
    localparam logic [16:0] SEQ [10] = '{17'h1_2555, 17'h1_DAAA, 17'h0_1333, 17'h0_ECCC,
        17'h0_00FF, 17'h1_FF00, 17'h1_DAAA, 17'h0_ECCC, 17'h0_FF00, 17'h0_0000};
    wire [15:0] word = mem[lat];
    wire drv = !cs_n && slp_n && !oe_n && we_n && rd_cyc && rdy;
    wire seq_wr = step >= 4'h6 && step <= 4'h8 && lat == SEQ[step];
    // Released lanes show the inverse of the last value, never a stale copy
    assign dq_out[15:8] = (drv && !upper_byte_n) ? word[15:8] : ~last[15:8];
    assign dq_out[7:0] = (drv && !lower_byte_n) ? word[7:0] : ~last[7:0];
    initial foreach (mem[i]) mem[i] = 16'h0000;
    // Commit one word; sequence writes and protected sectors leave the array alone
    task automatic put(input logic [15:0] d);
        if (!seq_wr && !prot[lat[16:14]])
        begin
            if (!upper_byte_n) mem[lat][15:8] = d[15:8];
            if (!lower_byte_n) mem[lat][7:0] = d[7:0];
        end
    endtask
    // Select fall latches the address; strobe level picks read or write
    always @(negedge cs_n) if (slp_n)
    begin
        lat = addr;
        last = dq_in;
        rd_cyc = we_n;
        wr_open = !we_n;
        rdy = 1'b0;
        #ACC_NS rdy = 1'b1;
    end
    // With select held low, a column change gives the next word at once and a row
    // change reopens the row; the controller never moves the address while selected
    always @(addr) if (!cs_n && slp_n)
    begin
        rdy = addr[16:2] == lat[16:2];
        lat = addr;
        if (!rdy) #ACC_NS rdy = 1'b1;
    end
    // A late strobe floats the bus and opens the write
    always @(negedge we_n) if (!cs_n && slp_n)
    begin
        rd_cyc = 1'b0;
        wr_open = 1'b1;
    end
    // Strobe and select may rise in one step; whichever block runs first commits
    // once, before the protection sequence moves on
    always @(posedge we_n) if (wr_open && slp_n)
    begin
        wr_open = 1'b0;
        put(dq_in);
    end
    // Select rise ends the access and advances the protection sequence
    always @(posedge cs_n) if (slp_n)
    begin
        if (wr_open)
        begin
            wr_open = 1'b0;
            put(dq_in);
        end
        if (lat == SEQ[step] && (!rd_cyc) == (step >= 4'h6 && step <= 4'h8))
        begin
            if (step == 4'h6) pend = dq_in[7:0];
            if (step == 4'h7 && dq_in[7:0] != ~pend) step = 4'h0;
            else if (step == 4'h9) {prot, step} = {pend, 4'h0};
            else step = step + 4'h1;
        end
        else step = (lat == SEQ[0] && rd_cyc) ? 4'h1 : 4'h0;
    end
endmodule

//--- sim/awp_host_tb.sv
// Self-checking bench: AXI4-Lite driver, memory model and scoreboard
`timescale 1ns/1ps
module awp_host_tb;
    import awp_pkg::*;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, s;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, oe_n, cs_n, we_n, ren_n, slp_n;
    wire upper_byte_n, lower_byte_n;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [16:0] maddr;
    wire [15:0] dqo, dq_mdl, dq;
    logic [34:0] exp_r [$], e;
    logic [1:0] exp_b [$];
    int err_total = 0, total_checks = 0, cyc = 0;
    logic [16:0] ad [8];
    logic [15:0] dat [8], nd;
    assign dq = !oe_n ? dqo : dq_mdl;
    always #12.5 MCLK = ~MCLK;
    awp_host dut_u (.MCLK(MCLK), .RST_N(RST_N), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .MEM_ADDR(maddr), .MEM_DQ_O(dqo), .MEM_DQ_I(dq), .MEM_DQ_OE_N(oe_n),
        .MEM_CHIP_SEL_N(cs_n), .MEM_WRITE_N(we_n), .MEM_OUT_EN_N(ren_n),
        .MEM_UPPER_BYTE_N(upper_byte_n), .MEM_LOWER_BYTE_N(lower_byte_n),
        .MEM_SLEEP_N(slp_n));
    awp_mem_model mem_u (.cs_n(cs_n), .we_n(we_n), .oe_n(ren_n),
        .upper_byte_n(upper_byte_n), .lower_byte_n(lower_byte_n),
        .slp_n(slp_n), .addr(maddr), .dq_in(dq), .dq_out(dq_mdl));
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        total_checks++;
        if (seen !== want)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // AXI write: each channel released at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        // The loop test sees values from before each edge, so one idle edge ends a call
        do
        begin
            @(posedge MCLK);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid) bready <= 1'b0;
        end
        while (awvalid || wvalid || bready);
    endtask
    // AXI read; c says whether the monitor compares the answer
    task automatic rd(input logic [7:0] a, input logic c, input logic [33:0] x);
        exp_r.push_back({c, x});
        {araddr, arvalid, rready} <= {a, 2'b11};
        do
        begin
            @(posedge MCLK);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid) {rready, s} <= {1'b0, rdata};
        end
        while (arvalid || rready);
    endtask
    // One memory operation, waited for through the done flag
    task automatic op(input logic [3:0] cmd, input logic [16:0] a, input logic [15:0] d);
        wr(REG_ADDR, 32'(a), RESP_OKAY);
        wr(REG_WDATA, 32'(d), RESP_OKAY);
        wr(REG_CMD, 32'(cmd), RESP_OKAY);
        rd(REG_STATUS, 1'b0, 34'h0_0000_0000);
        while (s[ST_DONE] !== 1'b1) rd(REG_STATUS, 1'b0, 34'h0_0000_0000);
        wr(REG_STATUS, 32'h0000_0002, RESP_OKAY);
    endtask
    task automatic memrd(input logic [16:0] a, input logic [15:0] x);
        op(4'h0, a, 16'h0000);
        rd(REG_RDATA, 1'b1, {RESP_OKAY, 32'(x)});
    endtask
    // Scoreboard: oldest note against each completed response
    always @(posedge MCLK)
    begin
        if (rvalid && rready) e = exp_r.pop_front();
        if (rvalid && rready && e[34]) check({rresp, rdata}, e[33:0]);
        if (bvalid && bready) check(34'(bresp), 34'(exp_b.pop_front()));
    end
    // Hang guard, well above the roughly 1300 cycles the run needs
    always @(posedge MCLK)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        void'($urandom(32'h7a2a_766f));
        repeat (10) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        rd(REG_STATUS, 1'b1, {RESP_OKAY, 32'h0000_0000});
        rd(8'h18, 1'b1, {RESP_SLVERR, 32'h0000_0000});
        wr(8'h1C, 32'h0000_0001, RESP_SLVERR);
        // One random word per sector, written then read back
        for (int k = 0; k < 8; k++)
        begin
            ad[k] = {3'(k), 14'($urandom())};
            dat[k] = 16'($urandom());
            op(4'h1, ad[k], dat[k]);
            memrd(ad[k], dat[k]);
        end
        // Upper lane only: the lower byte must survive
        nd = 16'($urandom());
        op(4'h9, ad[0], nd);
        dat[0][15:8] = nd[15:8];
        memrd(ad[0], dat[0]);
        // Protect sectors 3 and 4, then try to overwrite every sector
        op(4'h1, 17'h1_DAAA, 16'h1234);
        op(4'h2, 17'h0_0000, 16'h0018);
        memrd(17'h1_DAAA, 16'h1234);
        for (int k = 0; k < 8; k++)
        begin
            op(4'h1, ad[k], ~dat[k]);
            memrd(ad[k], (k == 3 || k == 4) ? dat[k] : ~dat[k]);
        end
        // Sleep: a command is refused, then wake and access again
        wr(REG_SLEEP, 32'h0000_0001, RESP_OKAY);
        wr(REG_CMD, 32'h0000_0001, RESP_OKAY);
        // Asleep counts as not idle, so busy stands beside asleep and err
        rd(REG_STATUS, 1'b1, {RESP_OKAY, 32'h0000_000D});
        wr(REG_STATUS, 32'h0000_0008, RESP_OKAY);
        wr(REG_SLEEP, 32'h0000_0000, RESP_OKAY);
        s = 32'h0000_0004;
        while (s[ST_ASLEEP] !== 1'b0) rd(REG_STATUS, 1'b0, 34'h0_0000_0000);
        memrd(ad[1], ~dat[1]);
        report_and_stop();
    end
endmodule
